// [include/cfg_id_regs.svh]
// Address map, field positions and erased values of the configuration and id block
// Assumes a byte-wide table address space of 22 bits
`ifndef CFG_ID_REGS_SVH
`define CFG_ID_REGS_SVH
// ----------------------------------------
// Addresses
// ----------------------------------------
`define ADDR_W 22
`define ID_BASE 22'h20_0000
`define ID_LAST 22'h20_0004
`define PART_ID_LOW_ADDR 22'h03_FFFE
`define PART_ID_HIGH_ADDR 22'h03_FFFF
`define CFG_BASE 22'h30_0000
`define CFG_LAST 22'h30_0005
// ----------------------------------------
// Configuration byte indices
// ----------------------------------------
`define CFG_PROT_IDX 0
`define CFG_OSC_IDX 1
`define CFG_WDT_IDX 2
`define CFG_MISC_IDX 3
`define CFG_BUS_IDX 4
`define CFG_EEP_IDX 5
`define CFG_BYTES 6
`define ID_BYTES 5
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PROT_POS 0
`define EEP_PROT_POS 0
`define WAIT_POS 0
`define STACK_RST_POS 1
`define CAPMUX_POS 2
`define UPPER_ADDR_POS 0
`define MID_HIGH_ADDR_POS 1
`define MID_LOW_ADDR_POS 2
`define BYTE_ADDR_POS 3
`define BYTE_SEL_POS 4
`define WRITE_STROBE_POS 5
`define REV_W 5
`define PART_W 11
// ----------------------------------------
// Values
// ----------------------------------------
`define CFG_IMPL 48'h013F_0707_0701
`define ERASED_BYTE 8'hFF
`define BLANK_READ 8'h00
`endif

// [include/cfg_id_pkg.sv]
// Types shared by the configuration and id block
// Assumes nothing beyond a SystemVerilog compiler
package cfg_id_pkg;
    typedef enum logic [2:0] {
        prog_none, prog_read, prog_write, prog_bulk_erase, prog_eeprom_erase, prog_config_erase
    } prog_cmd_t;
    typedef struct packed {
        logic valid;
        prog_cmd_t cmd;
        logic [21:0] addr;
        logic [7:0] wdata;
    } prog_req_t;
    typedef struct packed {
        logic valid;
        logic [21:0] addr;
    } table_read_t;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } read_resp_t;
    typedef enum logic [2:0] {
        low_power_crystal_mode, crystal_mode, high_speed_crystal_mode, high_speed_pll_mode,
        resistor_capacitor_mode, rc_with_io_pin_mode, external_clock_mode,
        external_clock_io_pin_mode
    } osc_mode_t;
    typedef struct packed {
        osc_mode_t osc;
        logic [2:0] wdt_div_log2;
        logic wait_enable;
        logic stack_fault_reset_enable;
        logic capture_pin_mux_select;
        logic upper_address_driver_disable;
        logic mid_high_address_driver_disable;
        logic mid_low_address_driver_disable;
        logic byte_address_driver_disable;
        logic byte_select_driver_disable;
        logic write_strobe_driver_disable;
    } session_cfg_t;
endpackage : cfg_id_pkg

// [verilog/nv_byte_bank.sv]
// Bank of nonvolatile bytes: programming clears bits, erase sets them
// Assumes por is a synchronous power-on reset that loads the factory image
`include "cfg_id_regs.svh"
module nv_byte_bank #(
    parameter int N = 5,
    parameter int IDX_W = 3,
    parameter logic [N*8-1:0] IMPL = '1,
    parameter logic [N*8-1:0] INIT = '1
) (
    input wire logic clk,
    input wire logic por,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [IDX_W-1:0] wr_idx,
    input wire logic [7:0] wr_data,
    input wire logic [N-1:0] erase_mask,
    output logic [N*8-1:0] bytes
);
    import cfg_id_pkg::*;
    logic [N*8-1:0] store;
    logic [N*8-1:0] next_store;
    // ----------------------------------------
    // Erase wins over a program in the same cycle
    // ----------------------------------------
    always_comb begin
        next_store = store;
        for (int i = 0; i < N; i++) begin
            if (erase_mask[i]) begin
                next_store[i*8 +: 8] = `ERASED_BYTE & IMPL[i*8 +: 8];
            end else if (wr_en && wr_idx == IDX_W'(i)) begin
                next_store[i*8 +: 8] = store[i*8 +: 8] & wr_data;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (por) begin
            store <= INIT & IMPL;
        end else if (ce) begin
            store <= next_store;
        end
    end
    assign bytes = store;
endmodule : nv_byte_bank

// [verilog/read_port.sv]
// One reader of the table space: part id word, id bytes, configuration, program memory
// Assumes program memory data for req.addr is valid in the request cycle
`include "cfg_id_regs.svh"
module read_port #(
    parameter int ID_N = 5,
    parameter int CFG_N = 6
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input cfg_id_pkg::table_read_t req,
    input wire logic [ID_N*8-1:0] id_bytes,
    input wire logic [15:0] part_id_word,
    input wire logic [CFG_N*8-1:0] cfg_bytes,
    input wire logic [7:0] pmem_rdata,
    input wire logic block_pmem,
    output cfg_id_pkg::read_resp_t resp
);
    import cfg_id_pkg::*;
    read_resp_t next_resp;
    // ----------------------------------------
    // Address decode, one cycle to the answer
    // ----------------------------------------
    always_comb begin
        next_resp.valid = req.valid;
        next_resp.data = `BLANK_READ;
        if (req.valid) begin
            if (req.addr == `PART_ID_LOW_ADDR) begin
                next_resp.data = part_id_word[7:0];
            end else if (req.addr == `PART_ID_HIGH_ADDR) begin
                next_resp.data = part_id_word[15:8];
            end else if (req.addr >= `ID_BASE && req.addr <= `ID_LAST) begin
                for (int i = 0; i < ID_N; i++) begin
                    if (req.addr == `ID_BASE + 22'(i)) begin
                        next_resp.data = id_bytes[i*8 +: 8];
                    end
                end
            end else if (req.addr >= `CFG_BASE && req.addr <= `CFG_LAST) begin
                for (int i = 0; i < CFG_N; i++) begin
                    if (req.addr == `CFG_BASE + 22'(i)) begin
                        next_resp.data = cfg_bytes[i*8 +: 8];
                    end
                end
            end else if (req.addr < `ID_BASE && !block_pmem) begin
                next_resp.data = pmem_rdata;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            resp <= '0;
        end else if (ce) begin
            resp <= next_resp;
        end
    end
endmodule : read_port

// [verilog/config_protect_and_id_access.sv]
// Configuration settings, code protection and id access for core and programmer
// Assumes the programmer request port is decoded on clk; por loads the factory image
`include "cfg_id_regs.svh"
// Summary of operation
// - Programmer reads program memory only while program protection is unprogrammed.
// - Eeprom protection is its own erasable bit, apart from mask-fixed program protection.
// - Factory state: eeprom protection off only when program protection is off.
// - Finishing the full eeprom erase clears eeprom protection, allowing eeprom writes.
// - Five user id bytes live at 200000h to 200004h.
// - Id bytes are readable by core table reads and by the programmer.
// - Id bytes read true values even while program memory is protected.
// - A fixed read-only two-byte part id word sits at 3FFFEh and 3FFFFh.
// - Part id word readable by core and programmer, even when protected.
// - Low byte bits 4 to 0 hold the silicon revision.
// - Eleven-bit part number: upper eight in high byte, lowest three in bits 7:5.
// - Bulk erase blanks program memory but leaves configuration untouched.
// - Watchdog postscale selects 1:1 to 1:128 in eight powers of two.
// - Oscillator setting picks one of eight clock source modes.
// - One setting enables wait states on external data bus accesses.
// - Separate settings disable each group of system bus drivers.
// - One setting chooses whether stack full or overflow forces a reset.
// - One setting picks the pin for the second capture unit output.
// - Configuration bits read 0 when programmed, 1 when erased.
// - Program protection bit 0 protects all program memory, 1 leaves it open.
module config_protect_and_id_access #(
    parameter logic MASK_PROGRAM_PROTECT = 1'b1,
    parameter logic [10:0] PART_NUMBER = 11'h2A5,
    parameter logic [4:0] SILICON_REVISION = 5'h03
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic por,
    input wire logic ce,
    input cfg_id_pkg::table_read_t table_read_instruction,
    input wire logic [7:0] core_pmem_rdata,
    output cfg_id_pkg::read_resp_t core_resp,
    input cfg_id_pkg::prog_req_t prog_req,
    input wire logic [7:0] prog_pmem_rdata,
    output cfg_id_pkg::read_resp_t prog_resp,
    output logic prog_busy,
    output logic program_erase_pulse,
    output logic eeprom_erase_start,
    input wire logic eeprom_erase_done,
    output logic eeprom_write_enable,
    output logic program_protected,
    output logic eeprom_protected,
    output cfg_id_pkg::session_cfg_t session_cfg
);
    import cfg_id_pkg::*;
    // Part number and revision defaults are arbitrary values
    localparam logic [15:0] PART_ID_WORD = {PART_NUMBER, SILICON_REVISION};
    localparam logic [47:0] CFG_IMPL_ALL = `CFG_IMPL;
    localparam logic [39:0] CFG_BANK_IMPL = CFG_IMPL_ALL[47:8];
    localparam logic [39:0] CFG_BANK_INIT = {7'h7F, MASK_PROGRAM_PROTECT, 32'hFFFF_FFFF};

    typedef enum {st_idle, st_eeprom_wait} erase_state_t;

    // ----------------------------------------
    // Setting decode
    // ----------------------------------------
    function automatic session_cfg_t decode_cfg(input logic [47:0] c);
        session_cfg_t s;
        logic [7:0] misc;
        logic [7:0] bus;
        misc = c[`CFG_MISC_IDX*8 +: 8];
        bus = c[`CFG_BUS_IDX*8 +: 8];
        case (c[`CFG_OSC_IDX*8 +: 3])
            3'h7: s.osc = rc_with_io_pin_mode;
            3'h6: s.osc = high_speed_pll_mode;
            3'h5: s.osc = external_clock_io_pin_mode;
            3'h4: s.osc = external_clock_mode;
            3'h3: s.osc = resistor_capacitor_mode;
            3'h2: s.osc = high_speed_crystal_mode;
            3'h1: s.osc = crystal_mode;
            default: s.osc = low_power_crystal_mode;
        endcase
        s.wdt_div_log2 = ~c[`CFG_WDT_IDX*8 +: 3];
        s.wait_enable = ~misc[`WAIT_POS];
        s.stack_fault_reset_enable = misc[`STACK_RST_POS];
        s.capture_pin_mux_select = misc[`CAPMUX_POS];
        s.upper_address_driver_disable = ~bus[`UPPER_ADDR_POS];
        s.mid_high_address_driver_disable = ~bus[`MID_HIGH_ADDR_POS];
        s.mid_low_address_driver_disable = ~bus[`MID_LOW_ADDR_POS];
        s.byte_address_driver_disable = ~bus[`BYTE_ADDR_POS];
        s.byte_select_driver_disable = ~bus[`BYTE_SEL_POS];
        s.write_strobe_driver_disable = ~bus[`WRITE_STROBE_POS];
        return s;
    endfunction : decode_cfg

    localparam session_cfg_t SESSION_RST = decode_cfg('1);

    logic [39:0] id_bytes;
    logic [39:0] cfg_bank;
    logic [47:0] cfg_all;
    logic prog_is_read;
    logic prog_act;
    logic id_hit;
    logic cfg_hit;
    logic id_wr;
    logic cfg_wr;
    logic [2:0] id_idx;
    logic [2:0] cfg_idx;
    logic [4:0] id_erase;
    logic [4:0] cfg_erase;
    table_read_t prog_rd;
    erase_state_t state;
    erase_state_t next_state;
    logic next_program_erase_pulse;
    logic next_eeprom_erase_start;
    logic sample_pending;
    logic next_sample_pending;
    session_cfg_t next_session_cfg;

    // ----------------------------------------
    // Programmer command decode
    // ----------------------------------------
    assign prog_act = prog_req.valid && state == st_idle;
    assign prog_is_read = prog_req.valid && prog_req.cmd == prog_read;
    assign id_hit = prog_req.addr >= `ID_BASE && prog_req.addr <= `ID_LAST;
    assign cfg_hit = prog_req.addr > `CFG_BASE && prog_req.addr <= `CFG_LAST;
    assign id_idx = 3'(prog_req.addr - `ID_BASE);
    assign cfg_idx = 3'(prog_req.addr - `CFG_BASE - 22'h00_0001);
    assign id_wr = prog_act && prog_req.cmd == prog_write && id_hit;
    assign cfg_wr = prog_act && prog_req.cmd == prog_write && cfg_hit;
    assign id_erase = {5{prog_act && prog_req.cmd == prog_bulk_erase}};
    // Config erase returns every setting; eeprom erase completion releases only its lock
    always_comb begin
        cfg_erase = {5{prog_act && prog_req.cmd == prog_config_erase}};
        if (state == st_eeprom_wait && eeprom_erase_done) begin
            cfg_erase[`CFG_EEP_IDX-1] = 1'b1;
        end
    end
    assign prog_rd.valid = prog_is_read;
    assign prog_rd.addr = prog_req.addr;

    // ----------------------------------------
    // Nonvolatile storage
    // ----------------------------------------
    nv_byte_bank #(
        .N(`ID_BYTES),
        .IDX_W(3),
        .IMPL('1),
        .INIT('1)
    ) u_id_bank (
        .clk(clk),
        .por(por),
        .ce(ce),
        .wr_en(id_wr),
        .wr_idx(id_idx),
        .wr_data(prog_req.wdata),
        .erase_mask(id_erase),
        .bytes(id_bytes)
    );

    // Mask-fixed program protection is outside the bank; factory eeprom lock follows it
    nv_byte_bank #(
        .N(`CFG_BYTES - 1),
        .IDX_W(3),
        .IMPL(CFG_BANK_IMPL),
        .INIT(CFG_BANK_INIT)
    ) u_cfg_bank (
        .clk(clk),
        .por(por),
        .ce(ce),
        .wr_en(cfg_wr),
        .wr_idx(cfg_idx),
        .wr_data(prog_req.wdata),
        .erase_mask(cfg_erase),
        .bytes(cfg_bank)
    );

    assign cfg_all = {cfg_bank, 7'h00, MASK_PROGRAM_PROTECT};
    assign program_protected = ~cfg_all[`CFG_PROT_IDX*8 + `PROT_POS];
    assign eeprom_protected = ~cfg_all[`CFG_EEP_IDX*8 + `EEP_PROT_POS];
    assign eeprom_write_enable = ~eeprom_protected;

    // ----------------------------------------
    // Readers
    // ----------------------------------------
    read_port #(
        .ID_N(`ID_BYTES),
        .CFG_N(`CFG_BYTES)
    ) u_core_port (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .req(table_read_instruction),
        .id_bytes(id_bytes),
        .part_id_word(PART_ID_WORD),
        .cfg_bytes(cfg_all),
        .pmem_rdata(core_pmem_rdata),
        .block_pmem(1'b0),
        .resp(core_resp)
    );

    read_port #(
        .ID_N(`ID_BYTES),
        .CFG_N(`CFG_BYTES)
    ) u_prog_port (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .req(prog_rd),
        .id_bytes(id_bytes),
        .part_id_word(PART_ID_WORD),
        .cfg_bytes(cfg_all),
        .pmem_rdata(prog_pmem_rdata),
        .block_pmem(program_protected),
        .resp(prog_resp)
    );

    // ----------------------------------------
    // Erase sequencing
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_program_erase_pulse = 1'b0;
        next_eeprom_erase_start = 1'b0;
        case (state)
            st_idle: begin
                if (prog_act && prog_req.cmd == prog_eeprom_erase) begin
                    next_eeprom_erase_start = 1'b1;
                    next_state = st_eeprom_wait;
                end
                if (prog_act && prog_req.cmd == prog_bulk_erase) begin
                    next_program_erase_pulse = 1'b1;
                end
            end
            st_eeprom_wait: begin
                if (eeprom_erase_done) begin
                    next_state = st_idle;
                end
            end
            default: next_state = st_idle;
        endcase
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= st_idle;
            program_erase_pulse <= 1'b0;
            eeprom_erase_start <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            program_erase_pulse <= next_program_erase_pulse;
            eeprom_erase_start <= next_eeprom_erase_start;
        end
    end
    assign prog_busy = state != st_idle;

    // ----------------------------------------
    // Session capture
    // ----------------------------------------
    always_comb begin
        next_sample_pending = 1'b0;
        next_session_cfg = session_cfg;
        if (sample_pending) begin
            next_session_cfg = decode_cfg(cfg_all);
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            sample_pending <= 1'b1;
            session_cfg <= SESSION_RST;
        end else if (ce) begin
            sample_pending <= next_sample_pending;
            session_cfg <= next_session_cfg;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_pmem_blocked;
        @(posedge clk) disable iff (srst || por || !ce)
        (prog_is_read && prog_req.addr < `PART_ID_LOW_ADDR && program_protected)
            |=> prog_resp.data == 8'h00;
    endproperty
    a_pmem_blocked: assert property (p_pmem_blocked) else $error("protected read leaked");

    property p_pmem_open;
        @(posedge clk) disable iff (srst || por || !ce)
        (prog_is_read && prog_req.addr < 22'h03_FFFE && !program_protected)
            |=> prog_resp.valid && prog_resp.data == $past(prog_pmem_rdata);
    endproperty
    a_pmem_open: assert property (p_pmem_open) else $error("open read wrong data");

    property p_factory_lock;
        @(posedge clk) disable iff (srst || !ce)
        $past(por) && !por |-> eeprom_protected == program_protected;
    endproperty
    a_factory_lock: assert property (p_factory_lock) else $error("factory lock mismatch");

    property p_erase_unlocks;
        @(posedge clk) disable iff (srst || por || !ce)
        (state == st_eeprom_wait && eeprom_erase_done)
            |=> !eeprom_protected && eeprom_write_enable && !prog_busy;
    endproperty
    a_erase_unlocks: assert property (p_erase_unlocks) else $error("erase kept lock");

    property p_erase_start;
        @(posedge clk) disable iff (srst || por || !ce)
        (prog_act && prog_req.cmd == prog_eeprom_erase) |=> eeprom_erase_start ##1 !eeprom_erase_start;
    endproperty
    a_erase_start: assert property (p_erase_start) else $error("erase start not one pulse");

    property p_id_read;
        @(posedge clk) disable iff (srst || por || !ce)
        (prog_is_read && prog_req.addr == `ID_LAST) |=> prog_resp.data == $past(id_bytes[39:32]);
    endproperty
    a_id_read: assert property (p_id_read) else $error("id byte wrong");

    property p_core_id;
        @(posedge clk) disable iff (srst || por || !ce)
        (table_read_instruction.valid && table_read_instruction.addr == `ID_BASE)
            |=> core_resp.valid && core_resp.data == $past(id_bytes[7:0]);
    endproperty
    a_core_id: assert property (p_core_id) else $error("core id byte wrong");

    property p_part_low;
        @(posedge clk) disable iff (srst || por || !ce)
        (prog_is_read && prog_req.addr == `PART_ID_LOW_ADDR)
            |=> prog_resp.data == {PART_NUMBER[2:0], SILICON_REVISION};
    endproperty
    a_part_low: assert property (p_part_low) else $error("part id low wrong");

    property p_part_high;
        @(posedge clk) disable iff (srst || por || !ce)
        (table_read_instruction.valid && table_read_instruction.addr == `PART_ID_HIGH_ADDR)
            |=> core_resp.data == PART_NUMBER[10:3];
    endproperty
    a_part_high: assert property (p_part_high) else $error("part id high wrong");

    property p_bulk_keeps_cfg;
        @(posedge clk) disable iff (srst || por || !ce)
        (prog_act && prog_req.cmd == prog_bulk_erase) |=> $stable(cfg_all) && program_erase_pulse;
    endproperty
    a_bulk_keeps_cfg: assert property (p_bulk_keeps_cfg) else $error("bulk erase hit config");

    property p_cfg_erased;
        @(posedge clk) disable iff (srst || por || !ce)
        (prog_act && prog_req.cmd == prog_config_erase) |=> cfg_bank == CFG_BANK_IMPL;
    endproperty
    a_cfg_erased: assert property (p_cfg_erased) else $error("erased config not ones");

    property p_session_hold;
        @(posedge clk) disable iff (srst || por || !ce)
        !sample_pending |=> $stable(session_cfg);
    endproperty
    a_session_hold: assert property (p_session_hold) else $error("session changed");

    property p_wdt_ratio;
        @(posedge clk) disable iff (srst || por || !ce)
        sample_pending |=> session_cfg.wdt_div_log2 == ~$past(cfg_all[`CFG_WDT_IDX*8 +: 3]);
    endproperty
    a_wdt_ratio: assert property (p_wdt_ratio) else $error("postscale wrong");

    c_protected_read: cover property (@(posedge clk) prog_is_read && program_protected);
    c_eeprom_unlock: cover property (@(posedge clk) state == st_eeprom_wait && eeprom_erase_done);
    c_bulk_erase: cover property (@(posedge clk) program_erase_pulse);
    c_session_load: cover property (@(posedge clk) sample_pending && !srst);
endmodule : config_protect_and_id_access

// [bench/prog_model.sv]
// Programmer model: issues one-cycle commands on the request port
// Assumes the bench calls its tasks; requests change at the falling edge
module prog_model (
    input wire logic clk,
    output cfg_id_pkg::prog_req_t req
);
    timeunit 1ns;
    timeprecision 1ns;
    import cfg_id_pkg::*;
    initial req = '0;
    // One command, held one cycle, then fields scrambled
    task automatic cmd(input prog_cmd_t c, input logic [21:0] a, input logic [7:0] d);
        @(negedge clk);
        req <= '{1'b1, c, a, d};
        @(negedge clk);
        req <= '{1'b0, prog_none, ~a, ~d};
    endtask : cmd
    // Whole array eeprom erase command only
    task automatic load_eeprom();
        cmd(prog_eeprom_erase, 22'h00_0000, 8'hFF);
    endtask : load_eeprom
endmodule : prog_model

// [bench/test_config_protect_and_id_access.sv]
// Testbench of the configuration and id block
// Assumes the programmer model drives the request port; the bench drives the rest
module test_config_protect_and_id_access;
    timeunit 1ns;
    timeprecision 1ns;
    import cfg_id_pkg::*;
    // Part number and revision are arbitrary values
    localparam logic [10:0] PN = 11'h5C3;
    localparam logic [4:0] REV = 5'h15;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic por = 1'b1;
    logic done = 1'b0;
    table_read_t trd = '0;
    read_resp_t core_resp, prog_resp;
    prog_req_t prog_req;
    session_cfg_t cfg;
    logic busy, perase, estart, ewe, pprot, eprot;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;
    prog_model u_prog (.clk(clk), .req(prog_req));
    config_protect_and_id_access #(.MASK_PROGRAM_PROTECT(1'b0), .PART_NUMBER(PN),
        .SILICON_REVISION(REV)) DUT (.clk(clk), .srst(srst), .por(por), .ce(1'b1),
        .table_read_instruction(trd), .core_pmem_rdata(8'h3C), .core_resp(core_resp),
        .prog_req(prog_req), .prog_pmem_rdata(8'h3C), .prog_resp(prog_resp),
        .prog_busy(busy), .program_erase_pulse(perase), .eeprom_erase_start(estart),
        .eeprom_erase_done(done), .eeprom_write_enable(ewe), .program_protected(pprot),
        .eeprom_protected(eprot), .session_cfg(cfg));
    initial forever #5 clk = ~clk;
    // ----------------------------------------
    // Checks and reads
    // ----------------------------------------
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        n_compared++;
        if (s !== e) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", n, e, s);
        end
    endtask : chk
    task automatic crd(input logic [21:0] a, input logic [7:0] e);
        @(negedge clk);
        trd <= '{1'b1, a};
        @(negedge clk);
        trd.valid <= 1'b0;
        chk("core_resp", {7'h0, 1'b1, e}, 16'(core_resp));
    endtask : crd
    task automatic prd(input logic [21:0] a, input logic [7:0] e);
        u_prog.cmd(prog_read, a, 8'h00);
        chk("prog_resp", {7'h0, 1'b1, e}, 16'(prog_resp));
    endtask : prd
    task automatic end_of_test();
        $display("compared %0d, errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_ids();
        chk("cfg", 16'({rc_with_io_pin_mode, 3'd0, 3'b011, 6'h00}), 16'(cfg));
        chk("pprot", 16'(1), 16'(pprot));
        chk("eprot", 16'(1), 16'(eprot));
        crd(22'h03_FFFE, {PN[2:0], REV});
        crd(22'h03_FFFF, PN[10:3]);
        u_prog.cmd(prog_write, 22'h03_FFFE, 8'h00);
        prd(22'h03_FFFE, {PN[2:0], REV});
        u_prog.cmd(prog_write, 22'h20_0004, 8'h5A);
        crd(22'h20_0004, 8'h5A);
        prd(22'h20_0004, 8'h5A);
        prd(22'h20_0000, 8'hFF);
        prd(22'h00_0010, 8'h00);
        crd(22'h00_0010, 8'h3C);
        crd(22'h20_0005, 8'h00);
    endtask : t_ids
    task automatic t_eeprom();
        u_prog.load_eeprom();
        chk("start", 16'(1), 16'(estart));
        chk("busy", 16'(1), 16'(busy));
        done <= 1'b1;
        @(negedge clk);
        done <= 1'b0;
        chk("eprot", 16'(0), 16'(eprot));
        chk("ewe", 16'(1), 16'(ewe));
        chk("busy", 16'(0), 16'(busy));
        u_prog.cmd(prog_write, 22'h30_0005, 8'hFE);
        chk("eprot", 16'(1), 16'(eprot));
        prd(22'h30_0005, 8'h00);
    endtask : t_eeprom
    task automatic t_cfg();
        u_prog.cmd(prog_write, 22'h30_0001, 8'hF6);
        u_prog.cmd(prog_write, 22'h30_0002, 8'h04);
        u_prog.cmd(prog_write, 22'h30_0003, 8'h00);
        u_prog.cmd(prog_write, 22'h30_0004, 8'h2A);
        chk("osc", 16'(rc_with_io_pin_mode), 16'(cfg.osc));
        u_prog.cmd(prog_bulk_erase, 22'h00_0000, 8'h00);
        chk("perase", 16'(1), 16'(perase));
        prd(22'h30_0002, 8'h04);
        srst <= 1'b1;
        @(negedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk("cfg", 16'({high_speed_pll_mode, 3'd3, 3'b100, 6'b101010}), 16'(cfg));
        u_prog.cmd(prog_config_erase, 22'h00_0000, 8'h00);
        chk("eprot", 16'(0), 16'(eprot));
        prd(22'h30_0001, 8'h07);
    endtask : t_cfg
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            end_of_test();
        end
    end
    initial begin
        repeat (8) @(negedge clk);
        srst <= 1'b0;
        por <= 1'b0;
        @(negedge clk);
        t_ids();
        t_eeprom();
        t_cfg();
        end_of_test();
    end
endmodule : test_config_protect_and_id_access
